// [manchester_codec_pkg.sv]
// Constants, carriers and helper functions for the Manchester codec and repeater.
// How it works
// - Encoder derives free-running 1X and 2X bit-rate timing from the system clock.
// - Transmit enable low drives outputs; high forces line outputs high, clock low.
// - Falling transmit enable sends eight Manchester zeros then a command sync.
// - Command sync lasts three bits: 1.5 bits high, then 1.5 bits low.
// - Source presents NRZ data; encoder samples it on each encoder clock fall.
// - After the preamble, data is encoded continuously while transmit enable stays low.
// - Manchester line outputs are driven in inverted, active-low polarity.
// - Decoder runs at 16X or 32X the bit rate, chosen by speed select.
// - Decoder always hunts for sync and tells command sync from data sync.
// - Each decoded bit leaves on serial output three bit periods after arrival.
// - Receive reset low forces data, clock and valid flag low; else clocked out.
// - After receive reset rises, valid flag stays low until a sync arrives.
// - Recovered clock lets external logic shift each bit on its falling edge.
// - An invalid Manchester bit drops the valid flag, aligned with that bit.
// - After a Manchester error, decoding resumes only at a new sync.
// - Repeater resends line input half a bit later with a 2X clock.
// - In repeater mode transmit enable only gates; no preamble is started.
// - In repeater mode the data/sync pin shows the latest sync type.
// - Slave reset goes low on receive reset; rises after sync, two good bits, first low.
// - Bipolar One: zero is low-to-high mid-cell, one is high-to-low; complement otherwise.
// - One bit period is 16 decoder ticks at 16X and 32 at 32X.
package manchester_codec_pkg;

  // Register byte offsets.
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STAT_OFF = 12'h004;

  // System clock period.
  localparam int CLK_PERIOD_NS = 50;

  // Decoder ticks per half bit at each speed.
  localparam logic [5:0] HALF_16X = 6'h08;
  localparam logic [5:0] HALF_32X = 6'h10;

  // Encoder sequence lengths in half bits.
  localparam logic [4:0] PRE_HALVES = 5'h10;
  localparam logic [4:0] SYNC_HALVES = 5'h06;
  localparam logic [4:0] SYNC_HIGH_HALVES = 5'h03;

  // Cells the decoder skips after the sync centre edge.
  localparam logic [1:0] SYNC_SKIP_CELLS = 2'h2;

  // Saturation value of the run-length counter.
  localparam logic [6:0] RUN_MAX = 7'h7F;

  // Control register layout.
  typedef struct packed {
    logic speed32;
    logic repeater;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{speed32: 1'b0, repeater: 1'b0};

  // Status register layout.
  typedef struct packed {
    logic hunting;
    logic enc_busy;
    logic slave_rst;
    logic cmd_sync;
    logic valid;
  } stat_t;

  // One decoded bit and its validity.
  typedef struct packed {
    logic valid;
    logic data;
  } dec_entry_t;

  localparam dec_entry_t ENTRY_NONE = '{valid: 1'b0, data: 1'b0};

  // Encoder sequence states.
  typedef enum logic [1:0] {E_IDLE, E_PRE, E_SYNC, E_DATA} enc_state_t;

  // Half-bit length in decoder ticks for the selected speed.
  function automatic logic [5:0] half_ticks(input logic speed32);
    return speed32 ? HALF_32X : HALF_16X;
  endfunction

  // True when a run of constant level lasts 1.25 to 1.75 bits.
  function automatic logic run_is_sync(input logic [6:0] len, input logic [5:0] h);
    logic [7:0] two_len;
    logic [7:0] lo;
    logic [7:0] hi;
    two_len = {len, 1'b0};
    lo = 8'({h, 2'b00} + {2'b00, h});
    hi = 8'({h, 3'b000} - {3'b000, h});
    return (two_len >= lo) && (two_len <= hi);
  endfunction

endpackage

// [manchester_codec_repeater.sv]
// Manchester II encoder, decoder and repeater with an APB control port.
`timescale 1ns/100ps
module manchester_codec_repeater
  import manchester_codec_pkg::*;
#(
  parameter int TICK_DIV = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic transmit_enable_n,
  input wire logic serial_in_or_sync_type_in,
  output logic serial_in_or_sync_type_out,
  output logic serial_in_or_sync_type_oe,
  output logic encoder_clock_out,
  output logic line_one_out_n,
  output logic line_zero_out_n,
  input wire logic line_one_in,
  input wire logic line_zero_in,
  input wire logic unipolar_line_in,
  input wire logic rx_reset_n,
  output logic decoded_serial_out,
  output logic recovered_clock_out,
  output logic valid_message_flag_n,
  output logic slave_reset_out_n
);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  localparam logic [15:0] TDIV_LAST = 16'(TICK_DIV - 1);

  logic [5:0] pin_m_q;
  logic [5:0] pin_s_q;
  logic cts_n_s, sdi_s, one_s, zero_s, uni_s, rxrst_s;
  logic [15:0] tdiv_q;
  logic tick;
  ctrl_t ctrl_q;
  logic repeater;
  logic [5:0] dec_half;
  logic [5:0] twoh;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic apb_hit;
  enc_state_t enc_st_q;
  logic [5:0] enc_hc_q;
  logic [4:0] enc_hi_q;
  logic enc_hp_q, enc_half_end, enc_pend_q, cts_d_q, enc_cur_q, enc_nxt_q;
  logic sync_high, enc_level;
  logic [15:0] rep_sr_q;
  logic rep_tap;
  logic one_q, zero_q, encoder_clock_out_q;
  logic rx_level, lvl_q, edge_now, sync_evt, mid_edge, dec_bound;
  logic sync_seen_q;
  logic [6:0] run_q;
  logic [5:0] dec_ph_q;
  logic [1:0] skip_q;
  logic s1_q, s2_q, hunt_q, cmd_q;
  dec_entry_t st0_q, st1_q;
  logic first_low_q, got_one_q, slave_reset_out_n_q;
  logic sdo_q, recovered_clock_out_q, nvm_q, sdt_out_q, sdt_oe_q;
  stat_t stat;

  // Two-stage synchroniser for every asynchronous pin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_m_q <= 6'h21;
      pin_s_q <= 6'h21;
    end else begin
      pin_m_q <= {rx_reset_n, unipolar_line_in, line_zero_in, line_one_in,
                  serial_in_or_sync_type_in, transmit_enable_n};
      pin_s_q <= pin_m_q;
    end
  end

  assign cts_n_s = pin_s_q[0];
  assign sdi_s = pin_s_q[1];
  assign one_s = pin_s_q[2];
  assign zero_s = pin_s_q[3];
  assign uni_s = pin_s_q[4];
  assign rxrst_s = pin_s_q[5];

  // Decoder tick divider; every rate in the block is a multiple of this tick.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdiv_q <= 16'h0000;
    end else begin
      tdiv_q <= (tdiv_q >= TDIV_LAST) ? 16'h0000 : tdiv_q + 16'h0001;
    end
  end

  assign tick = (tdiv_q >= TDIV_LAST);
  assign repeater = ctrl_q.repeater;
  assign dec_half = half_ticks(ctrl_q.speed32);
  assign twoh = {dec_half[4:0], 1'b0};

  // APB slave: zero wait states, setup cycle latches the answer.
  assign apb_hit = (paddr == CTRL_OFF) || (paddr == STAT_OFF);
  assign stat = '{hunting: hunt_q, enc_busy: (enc_st_q != E_IDLE), slave_rst: slave_reset_out_n_q,
                  cmd_sync: cmd_q, valid: nvm_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
      ctrl_q <= CTRL_RESET;
    end else begin
      pready_q <= psel && !penable;
      if (psel && !penable) begin
        pslverr_q <= !apb_hit;
        if (paddr == CTRL_OFF) begin
          prdata_q <= 32'(ctrl_q);
        end else if (paddr == STAT_OFF) begin
          prdata_q <= 32'(stat);
        end else begin
          prdata_q <= 32'h00000000;
        end
      end
      if (psel && penable && pready_q && pwrite && (paddr == CTRL_OFF)) begin
        ctrl_q <= ctrl_t'(pwdata[1:0]);
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // Free-running half-bit counter and cell parity give the 1X and 2X timing.
  assign enc_half_end = tick && (enc_hc_q >= dec_half - 6'h01);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_hc_q <= 6'h00;
      enc_hp_q <= 1'b0;
    end else if (tick) begin
      enc_hc_q <= enc_half_end ? 6'h00 : enc_hc_q + 6'h01;
      if (enc_half_end) begin
        enc_hp_q <= !enc_hp_q;
      end
    end
  end

  // Encoder sequencer; a new sequence starts at the next cell boundary.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_st_q <= E_IDLE;
      enc_hi_q <= 5'h00;
      enc_pend_q <= 1'b0;
      cts_d_q <= 1'b1;
    end else begin
      cts_d_q <= cts_n_s;
      if (cts_n_s || repeater) begin
        enc_st_q <= E_IDLE;
        enc_pend_q <= 1'b0;
      end else begin
        if (cts_d_q) begin
          enc_pend_q <= 1'b1;
        end
        if (enc_half_end) begin
          case (enc_st_q)
            E_IDLE: begin
              if (enc_pend_q && enc_hp_q) begin
                enc_st_q <= E_PRE;
                enc_hi_q <= 5'h00;
                enc_pend_q <= 1'b0;
              end
            end
            E_PRE: begin
              if (enc_hi_q == PRE_HALVES - 5'h01) begin
                enc_st_q <= E_SYNC;
                enc_hi_q <= 5'h00;
              end else begin
                enc_hi_q <= enc_hi_q + 5'h01;
              end
            end
            E_SYNC: begin
              if (enc_hi_q == SYNC_HALVES - 5'h01) begin
                enc_st_q <= E_DATA;
                enc_hi_q <= 5'h00;
              end else begin
                enc_hi_q <= enc_hi_q + 5'h01;
              end
            end
            E_DATA: begin
              enc_st_q <= E_DATA;
            end
            default: begin
              enc_st_q <= E_IDLE;
            end
          endcase
        end
      end
    end
  end

  // Serial input is taken at each encoder clock fall, used from the next cell.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_nxt_q <= 1'b0;
      enc_cur_q <= 1'b0;
    end else if (enc_half_end) begin
      if (!enc_hp_q) begin
        enc_nxt_q <= sdi_s;
      end else begin
        enc_cur_q <= enc_nxt_q;
      end
    end
  end

  // Line level before inversion, in the Bipolar One sense.
  assign sync_high = (enc_hi_q < SYNC_HIGH_HALVES);

  always_comb begin
    case (enc_st_q)
      E_PRE: enc_level = enc_hp_q;
      E_SYNC: enc_level = sync_high;
      E_DATA: enc_level = enc_hp_q ? !enc_cur_q : enc_cur_q;
      default: enc_level = 1'b0;
    endcase
  end

  // Half-bit delay line for the repeater path.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rep_sr_q <= 16'h0000;
    end else if (tick) begin
      rep_sr_q <= {rep_sr_q[14:0], rx_level};
    end
  end

  assign rep_tap = rep_sr_q[4'(dec_half - 6'h01)];

  // Transmit outputs, gated by transmit enable and driven active low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      one_q <= 1'b1;
      zero_q <= 1'b1;
      encoder_clock_out_q <= 1'b0;
    end else if (cts_n_s) begin
      one_q <= 1'b1;
      zero_q <= 1'b1;
      encoder_clock_out_q <= 1'b0;
    end else if (repeater) begin
      one_q <= !rep_tap;
      zero_q <= rep_tap;
      encoder_clock_out_q <= (enc_hc_q < (dec_half >> 1));
    end else begin
      encoder_clock_out_q <= !enc_hp_q;
      one_q <= (enc_st_q == E_IDLE) ? 1'b1 : !enc_level;
      zero_q <= (enc_st_q == E_IDLE) ? 1'b1 : enc_level;
    end
  end

  assign line_one_out_n = one_q;
  assign line_zero_out_n = zero_q;
  assign encoder_clock_out = encoder_clock_out_q;

  // Received level from either the bipolar pair or the unipolar input.
  assign rx_level = uni_s || (one_s && !zero_s);
  assign edge_now = tick && (rx_level != lvl_q);
  // The closing half of a sync is as long as its opening half, so the edge that ends it
  // must not count as a second sync of the opposite type.
  assign sync_evt = edge_now && !sync_seen_q && run_is_sync(run_q, dec_half);
  assign mid_edge = edge_now && !sync_evt && !hunt_q && (dec_ph_q > (dec_half >> 1))
                    && (dec_ph_q < dec_half + (dec_half >> 1));
  assign dec_bound = tick && (dec_ph_q >= twoh - 6'h01);

  // Run-length measurement between line transitions.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_q <= 1'b0;
      run_q <= 7'h00;
      sync_seen_q <= 1'b0;
    end else if (tick) begin
      lvl_q <= rx_level;
      if (edge_now) begin
        run_q <= 7'h01;
        sync_seen_q <= sync_evt;
      end else if (run_q != RUN_MAX) begin
        run_q <= run_q + 7'h01;
      end
    end
  end

  // Cell phase counter, realigned on the sync centre and on mid-cell edges.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_ph_q <= 6'h00;
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else if (tick) begin
      if (sync_evt || mid_edge) begin
        dec_ph_q <= dec_half;
      end else begin
        dec_ph_q <= dec_bound ? 6'h00 : dec_ph_q + 6'h01;
      end
      if (dec_ph_q == (dec_half >> 1)) begin
        s1_q <= rx_level;
      end
      if (dec_ph_q == dec_half + (dec_half >> 1)) begin
        s2_q <= rx_level;
      end
    end
  end

  // Sync hunt, bit decode, error detection and the three-bit output pipeline.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hunt_q <= 1'b1;
      skip_q <= 2'h0;
      cmd_q <= 1'b0;
      st0_q <= ENTRY_NONE;
      st1_q <= ENTRY_NONE;
    end else if (!rxrst_s) begin
      hunt_q <= 1'b1;
      skip_q <= 2'h0;
      st0_q <= ENTRY_NONE;
      st1_q <= ENTRY_NONE;
    end else if (sync_evt) begin
      hunt_q <= 1'b0;
      skip_q <= SYNC_SKIP_CELLS;
      cmd_q <= lvl_q;
    end else if (dec_bound) begin
      st1_q <= st0_q;
      if (skip_q != 2'h0) begin
        skip_q <= skip_q - 2'h1;
        st0_q <= ENTRY_NONE;
      end else if (hunt_q) begin
        st0_q <= ENTRY_NONE;
      end else begin
        st0_q <= '{valid: (s1_q != s2_q), data: s1_q};
        if (s1_q == s2_q) begin
          hunt_q <= 1'b1;
        end
      end
    end
  end

  // Slave reset release after sync, a low first bit and a second good bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slave_reset_out_n_q <= 1'b0;
      got_one_q <= 1'b0;
      first_low_q <= 1'b0;
    end else if (!rxrst_s) begin
      slave_reset_out_n_q <= 1'b0;
      got_one_q <= 1'b0;
    end else if (sync_evt) begin
      got_one_q <= 1'b0;
    end else if (dec_bound && skip_q == 2'h0 && !hunt_q && s1_q != s2_q) begin
      got_one_q <= 1'b1;
      if (!got_one_q) begin
        first_low_q <= !s1_q;
      end else if (first_low_q) begin
        slave_reset_out_n_q <= 1'b1;
      end
    end
  end

  // Decoder outputs, forced low while receive reset is low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdo_q <= 1'b0;
      nvm_q <= 1'b0;
      recovered_clock_out_q <= 1'b0;
    end else if (!rxrst_s) begin
      sdo_q <= 1'b0;
      nvm_q <= 1'b0;
      recovered_clock_out_q <= 1'b0;
    end else begin
      recovered_clock_out_q <= (dec_ph_q < dec_half);
      if (dec_bound) begin
        sdo_q <= st1_q.data;
        nvm_q <= st1_q.valid;
      end
    end
  end

  // Sync-type pin driver, active only in repeater mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdt_oe_q <= 1'b0;
      sdt_out_q <= 1'b0;
    end else begin
      sdt_oe_q <= repeater;
      sdt_out_q <= cmd_q;
    end
  end

  assign decoded_serial_out = sdo_q;
  assign valid_message_flag_n = nvm_q;
  assign recovered_clock_out = recovered_clock_out_q;
  assign slave_reset_out_n = slave_reset_out_n_q;
  assign serial_in_or_sync_type_out = sdt_out_q;
  assign serial_in_or_sync_type_oe = sdt_oe_q;

  // Checks on the encoder sequence, decoder pipeline and output gating.
  sequence s_pre_done;
    enc_st_q == E_PRE && enc_half_end && enc_hi_q == PRE_HALVES - 5'h01
      && !cts_n_s && !repeater;
  endsequence

  sequence s_err_bound;
    rxrst_s && dec_bound && !sync_evt && skip_q == 2'h0 && !hunt_q && s1_q == s2_q;
  endsequence

  sequence s_enc_start;
    enc_st_q == E_IDLE ##1 enc_st_q != E_IDLE;
  endsequence

  property p_tx_gate;
    cts_n_s |=> line_one_out_n && line_zero_out_n && !encoder_clock_out;
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("line outputs not gated");

  property p_pre_start;
    s_enc_start |-> enc_st_q == E_PRE && !repeater;
  endproperty
  a_pre_start: assert property (p_pre_start) else $error("bad sequence start");

  property p_pre_to_sync;
    s_pre_done |=> enc_st_q == E_SYNC && enc_hi_q == 5'h00;
  endproperty
  a_pre_to_sync: assert property (p_pre_to_sync) else $error("preamble length wrong");

  property p_rep_no_seq;
    repeater |=> enc_st_q == E_IDLE;
  endproperty
  a_rep_no_seq: assert property (p_rep_no_seq) else $error("sequence in repeater");

  property p_sync_shape;
    enc_st_q == E_SYNC && !cts_n_s && !repeater |=> line_one_out_n == !$past(sync_high);
  endproperty
  a_sync_shape: assert property (p_sync_shape) else $error("sync pulse shape wrong");

  property p_inverted;
    enc_st_q == E_DATA && !cts_n_s && !repeater
      |=> line_zero_out_n == $past(enc_level) && line_one_out_n != line_zero_out_n;
  endproperty
  a_inverted: assert property (p_inverted) else $error("data polarity wrong");

  property p_rx_reset;
    !rxrst_s |=> !decoded_serial_out && !recovered_clock_out && !valid_message_flag_n;
  endproperty
  a_rx_reset: assert property (p_rx_reset) else $error("decoder outputs not forced");

  property p_err_hunt;
    s_err_bound |=> hunt_q && !st0_q.valid;
  endproperty
  a_err_hunt: assert property (p_err_hunt) else $error("error not flagged");

  property p_hunt_hold;
    hunt_q && !sync_evt |=> hunt_q;
  endproperty
  a_hunt_hold: assert property (p_hunt_hold) else $error("decode resumed early");

  property p_pipe;
    dec_bound && rxrst_s |=> {valid_message_flag_n, decoded_serial_out} == $past(st1_q);
  endproperty
  a_pipe: assert property (p_pipe) else $error("output pipeline slip");

  property p_slave_rst;
    !rxrst_s |=> !slave_reset_out_n;
  endproperty
  a_slave_rst: assert property (p_slave_rst) else $error("slave reset not low");

  property p_sync_type;
    repeater |=> serial_in_or_sync_type_oe && serial_in_or_sync_type_out == $past(cmd_q);
  endproperty
  a_sync_type: assert property (p_sync_type) else $error("sync type pin wrong");

  property p_cell_wrap;
    dec_bound && !sync_evt && !mid_edge |=> dec_ph_q == 6'h00;
  endproperty
  a_cell_wrap: assert property (p_cell_wrap) else $error("cell length wrong");

endmodule

// [line_model.sv]
// Line-side model: comparator outputs of a transformer-coupled bus feeding the block.
`timescale 1ns/100ps
module line_model (
  input wire logic pclk,
  output logic line_one_in,
  output logic line_zero_in,
  output logic unipolar_line_in,
  output logic level
);
  logic uni_sel;

  // The bus starts idle, with both comparators low, so the sensed level is low.
  initial begin
    uni_sel = 1'b0;
    line_one_in = 1'b0;
    line_zero_in = 1'b0;
    unipolar_line_in = 1'b0;
    level = 1'b0;
  end

  // Hold one line level for n clock cycles on the chosen input style.
  task automatic put(input logic lv, input int n);
    level <= lv;
    line_one_in <= uni_sel ? 1'b0 : lv;
    line_zero_in <= uni_sel ? 1'b1 : ~lv;
    unipolar_line_in <= uni_sel ? lv : 1'b0;
    repeat (n) @(posedge pclk);
  endtask

  // Send a sync and n cells; the cell at index bad has no mid-cell transition.
  task automatic send(input logic cmd, input logic uni, input logic [31:0] b, input int n,
      input int bad, input int h);
    uni_sel = uni;
    put(~cmd, 2 * h);
    put(cmd, 3 * h);
    put(~cmd, 3 * h);
    for (int i = 0; i < n; i++) begin
      put(b[i], h);
      put((i == bad) ? b[i] : ~b[i], h);
    end
    uni_sel = 1'b0;
    put(1'b0, 1);
  endtask
endmodule

// [tb.sv]
// Testbench for the Manchester codec: register access, decoder, encoder and repeater.
`timescale 1ns/100ps
module tb;
  import manchester_codec_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, r;
  logic pready, pslverr, e, lv, rc_q;
  logic [31:0] txd = 32'h00000000;
  logic transmit_enable_n = 1'b1, sd_drv = 1'b0, rx_reset_n = 1'b0;
  logic serial_in_or_sync_type_in, serial_in_or_sync_type_out, serial_in_or_sync_type_oe;
  logic encoder_clock_out, line_one_out_n, line_zero_out_n;
  logic line_one_in, line_zero_in, unipolar_line_in, line_level;
  logic decoded_serial_out, recovered_clock_out, valid_message_flag_n, slave_reset_out_n;
  logic [15:0] seed = 16'h382B;
  logic got[$];
  int n_fail = 0;
  int checks = 0;
  int n;

  manchester_codec_repeater #(.TICK_DIV(1)) i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .transmit_enable_n, .serial_in_or_sync_type_in, .serial_in_or_sync_type_out,
    .serial_in_or_sync_type_oe, .encoder_clock_out, .line_one_out_n, .line_zero_out_n,
    .line_one_in, .line_zero_in, .unipolar_line_in, .rx_reset_n, .decoded_serial_out,
    .recovered_clock_out, .valid_message_flag_n, .slave_reset_out_n
  );

  line_model i_line (.pclk, .line_one_in, .line_zero_in, .unipolar_line_in, .level(line_level));

  // The data/sync pin carries the block's value while it drives, else the bench's.
  assign serial_in_or_sync_type_in = serial_in_or_sync_type_oe ? serial_in_or_sync_type_out : sd_drv;

  // Clock of 50 ns period.
  always #25 pclk = ~pclk;

  // Collect each bit flagged valid at the fall of the recovered clock.
  always @(posedge pclk) begin
    rc_q <= recovered_clock_out;
    if (rc_q === 1'b1 && recovered_clock_out === 1'b0 && valid_message_flag_n === 1'b1) begin
      got.push_back(decoded_serial_out);
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic er);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) n_fail++;
  endtask

  // Send a frame of random bits and compare what the decoder delivers as valid.
  task automatic frame(input logic cmd, input logic uni, input int nb, input int bad, input int h);
    logic [31:0] b;
    int k;
    for (int i = 0; i < 32; i++) begin
      seed = lfsr(seed);
      b[i] = seed[0];
    end
    b[0] = 1'b0;
    if (bad < nb) begin
      b[bad-1] = b[bad];
      b[bad+1] = ~b[bad];
    end
    got.delete();
    i_line.send(cmd, uni, b, nb, bad, h);
    repeat (12 * h) @(posedge pclk);
    k = (bad < nb) ? bad : nb;
    chk("bit count", got.size(), k);
    for (int i = 0; i < k; i++) chk("decoded bit", got[i], b[i]);
    $display("frame done cmd %0d bits %0d", cmd, nb);
  endtask

  // Cut a hung run short.
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    give_verdict();
  end

  // Main sequence.
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTRL_OFF, 32'h0, r, e);
    chk("ctrl reset", r, 32'h00000000);
    chk("ctrl reset error", e, 1'b0);
    apb(1'b0, 12'h008, 32'h0, r, e);
    chk("unmapped data", r, 32'h00000000);
    chk("unmapped error", e, 1'b1);
    apb(1'b1, CTRL_OFF, 32'h2, r, e);
    apb(1'b0, CTRL_OFF, 32'h0, r, e);
    chk("ctrl rw", r, 32'h2);
    $display("register access done");
    apb(1'b1, CTRL_OFF, 32'h0, r, e);
    repeat (24) @(posedge pclk);
    chk("rx held", {decoded_serial_out, recovered_clock_out, valid_message_flag_n,
      slave_reset_out_n}, 4'h0);
    rx_reset_n <= 1'b1;
    repeat (48) @(posedge pclk);
    chk("valid before sync", {valid_message_flag_n, 1'b0}, {1'b0, 1'b0});
    $display("receive reset done");
    frame(1'b1, 1'b0, 12, 99, 8);
    chk("slave reset", slave_reset_out_n, 1'b1);
    apb(1'b0, STAT_OFF, 32'h0, r, e);
    chk("command sync", r[1], 1'b1);
    frame(1'b0, 1'b1, 12, 6, 8);
    apb(1'b0, STAT_OFF, 32'h0, r, e);
    chk("data sync", r[1], 1'b0);
    chk("error flag", valid_message_flag_n, 1'b0);
    apb(1'b1, CTRL_OFF, 32'h2, r, e);
    frame(1'b1, 1'b0, 10, 99, 16);
    apb(1'b1, CTRL_OFF, 32'h0, r, e);
    sd_drv <= 1'b1;
    chk("idle lines", {line_one_out_n, line_zero_out_n, encoder_clock_out}, 3'b110);
    transmit_enable_n <= 1'b0;
    n = 0;
    while (line_zero_out_n !== 1'b0 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    repeat (4) @(posedge pclk);
    for (int i = 0; i < 26; i++) begin
      lv = (i < 16) ? i[0] : (i < 19) ? 1'b1 : (i < 22) ? 1'b0 : txd[(i >> 1) - 2] ^ i[0];
      chk("line level", line_zero_out_n, lv);
      chk("line pair", line_one_out_n, !lv);
      chk("encoder clock", encoder_clock_out, !i[0]);
      // A new random bit each cell, taken at the next clock fall and sent a cell later.
      if (i[0]) begin
        seed = lfsr(seed);
        txd[i >> 1] = seed[0];
        sd_drv <= seed[0];
      end
      repeat (8) @(posedge pclk);
    end
    transmit_enable_n <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("disabled lines", {line_one_out_n, line_zero_out_n, encoder_clock_out}, 3'b110);
    $display("encoder done");
    apb(1'b1, CTRL_OFF, 32'h1, r, e);
    transmit_enable_n <= 1'b0;
    apb(1'b0, STAT_OFF, 32'h0, r, e);
    chk("no preamble", r[3], 1'b0);
    fork
      i_line.send(1'b0, 1'b0, 32'h5, 4, 9, 8);
      begin
        repeat (20) @(posedge pclk);
        for (int i = 0; i < 12; i++) begin
          lv = line_level;
          repeat (8) @(posedge pclk);
          chk("repeated level", line_zero_out_n, lv);
        end
      end
    join
    chk("sync type", {serial_in_or_sync_type_oe, serial_in_or_sync_type_out}, 2'b10);
    $display("repeater done");
    give_verdict();
  end
endmodule
